// file: pwc_pkg.sv
// Shared constants and types for the periodic wake-up counter.
// Assumes a single 200 MHz system clock and APB register access.
package pwc_pkg;

	localparam logic [31:0] PWC_OFF_SC = 32'h0000_0000;
	localparam logic [31:0] PWC_OFF_CNT = 32'h0000_0004;
	localparam logic [31:0] PWC_OFF_MOD = 32'h0000_0008;

	localparam int PWC_FLAG_BIT = 7;
	localparam int PWC_SRC_HI = 6;
	localparam int PWC_SRC_LO = 5;
	localparam int PWC_IE_BIT = 4;
	localparam int PWC_SEL_HI = 3;
	localparam int PWC_SEL_LO = 0;

	localparam logic [7:0] PWC_COUNT_RST = 8'h00;
	localparam logic [7:0] PWC_MATCH_RST = 8'h00;
	localparam logic [1:0] PWC_SRC_LOW_POWER = 2'h0;
	localparam logic [1:0] PWC_SRC_EXT = 2'h1;
	localparam logic [3:0] PWC_SEL_OFF = 4'h0;
	localparam logic [17:0] PWC_DIV_RST = 18'h00000;
	localparam logic [17:0] PWC_DIV_ONE = 18'h00001;

	typedef struct packed {
		logic [1:0] src;
		logic irq_en;
		logic [3:0] sel;
	} pwc_cfg_t;

	localparam pwc_cfg_t PWC_CFG_RST = '{src: PWC_SRC_LOW_POWER, irq_en: 1'b0, sel: PWC_SEL_OFF};

	// Divide ratios, index 15 first; entry 0 is unused because selection 0 is off.
	localparam logic [15:0][17:0] PWC_DIV_LO = {
		18'h003E8, 18'h001F4, 18'h00064, 18'h00010, 18'h0000A, 18'h00004, 18'h00002, 18'h00001,
		18'h00400, 18'h00200, 18'h00100, 18'h00080, 18'h00040, 18'h00020, 18'h00008, 18'h00001};
	localparam logic [15:0][17:0] PWC_DIV_HI = {
		18'h30D40, 18'h186A0, 18'h0C350, 18'h04E20, 18'h02710, 18'h01388, 18'h007D0, 18'h003E8,
		18'h10000, 18'h08000, 18'h04000, 18'h02000, 18'h01000, 18'h00800, 18'h00400, 18'h00001};

endpackage : pwc_pkg

// file: pwc_prescaler.sv
// Binary and decimal prescaler driven by the selected source tick.
// Assumes tick is a one-cycle enable synchronous to sys_clk.
`timescale 1ns/100ps
module pwc_prescaler (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic tick,
	input wire logic [3:0] sel,
	input wire logic src0,
	output logic period
);
	logic [17:0] div_cnt_ff;
	logic [17:0] div_last;

	always_comb begin
		div_last = (src0 ? pwc_pkg::PWC_DIV_HI[sel] : pwc_pkg::PWC_DIV_LO[sel]) - pwc_pkg::PWC_DIV_ONE;
	end

	assign period = tick && (sel != pwc_pkg::PWC_SEL_OFF) && (div_cnt_ff == div_last);

	always_ff @(posedge sys_clk) begin
		if (sys_rst || clear || (sel == pwc_pkg::PWC_SEL_OFF)) begin
			div_cnt_ff <= pwc_pkg::PWC_DIV_RST;
		end else if (tick) begin
			div_cnt_ff <= period ? pwc_pkg::PWC_DIV_RST : div_cnt_ff + pwc_pkg::PWC_DIV_ONE;
		end
	end

endmodule : pwc_prescaler

// file: pwc_modcount.sv
// Eight-bit up-counter that wraps to zero on reaching the match value.
// Assumes step is a one-cycle enable from the prescaler.
`timescale 1ns/100ps
module pwc_modcount (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic step,
	input wire logic [7:0] match,
	output logic [7:0] count,
	output logic wrap
);
	logic [7:0] count_ff;

	assign wrap = step && (count_ff == match);
	assign count = count_ff;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || clear) begin
			count_ff <= pwc_pkg::PWC_COUNT_RST;
		end else if (wrap) begin
			count_ff <= pwc_pkg::PWC_COUNT_RST;
		end else if (step) begin
			count_ff <= count_ff + 8'h01;
		end
	end

endmodule : pwc_modcount

// file: pwc_top.sv
// Periodic wake-up counter with its APB register slave.
// Assumes source clocks arrive as one-cycle enables synchronous to sys_clk.
//
// Function
// - Current count is a read-only register; writes to it are ignored.
// - Count clears on reset, match write, or changed source or divider write.
// - Eight-bit match value; on match count returns to zero and flag sets.
// - Match value zero sets the flag on every prescaler period.
// - Match write clears prescaler and count; reset clears match value.
// - After reset: counter zero, match zero, prescaler off, low-power source.
// - Prescaler and counter stay halted while divider selection is zero.
// - Three sources; writing a different source clears prescaler and count.
// - Ratio set by divider selection and source bit 0; change clears both.
// - Divider selection zero turns prescaler off for every source encoding.
// - Match value accepts the full range zero to all ones.
// - Counter steps once per period, wraps to zero, keeps running.
// - Flag sets on the step from match value to zero.
// - Interrupt request while flag is set and interrupt enable is one.
// - Writing one to the flag clears flag and interrupt request.
// - Source code 00 low-power, 01 external, 1x internal reference.
// - Divider codes map to the binary and decimal ratio tables.
// - Status register: flag 7, source 6:5, enable 4, divider 3:0.
// - Debug halt suspends counting; counting resumes from the held value.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module pwc_top (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic low_power_osc_clock,
	input wire logic external_ref_clock,
	input wire logic internal_ref_clock,
	input wire logic debug_halt,
	output logic period_irq
);
	pwc_pkg::pwc_cfg_t cfg_ff;
	pwc_pkg::pwc_cfg_t nxt_cfg;
	logic [7:0] match_ff;
	logic period_flag_ff;
	logic tick_ff;
	logic [31:0] prdata_ff;
	logic access;
	logic addr_ok;
	logic wr_sc;
	logic wr_cnt;
	logic wr_mod;
	logic cfg_change;
	logic clr;
	logic src_tick;
	logic step_en;
	logic period;
	logic wrap;
	logic [7:0] current_count;
	logic [31:0] rd_mux;

	assign access = psel && penable;
	assign pready = access;
	assign addr_ok = (paddr == pwc_pkg::PWC_OFF_SC) ||
		(paddr == pwc_pkg::PWC_OFF_CNT) ||
		(paddr == pwc_pkg::PWC_OFF_MOD);
	assign pslverr = access && !addr_ok;
	assign prdata = prdata_ff;

	assign wr_sc = access && pwrite && (paddr == pwc_pkg::PWC_OFF_SC);
	assign wr_cnt = access && pwrite && (paddr == pwc_pkg::PWC_OFF_CNT);
	assign wr_mod = access && pwrite && (paddr == pwc_pkg::PWC_OFF_MOD);

	always_comb begin
		nxt_cfg.src = pwdata[pwc_pkg::PWC_SRC_HI:pwc_pkg::PWC_SRC_LO];
		nxt_cfg.irq_en = pwdata[pwc_pkg::PWC_IE_BIT];
		nxt_cfg.sel = pwdata[pwc_pkg::PWC_SEL_HI:pwc_pkg::PWC_SEL_LO];
	end

	// On a status write, only a changed source or divider restarts the chain.
	assign cfg_change = wr_sc && ((nxt_cfg.src != cfg_ff.src) || (nxt_cfg.sel != cfg_ff.sel));
	assign clr = wr_mod || cfg_change;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_ff <= pwc_pkg::PWC_CFG_RST;
		end else if (wr_sc) begin
			cfg_ff <= nxt_cfg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			match_ff <= pwc_pkg::PWC_MATCH_RST;
		end else if (wr_mod) begin
			match_ff <= pwdata[7:0];
		end
	end

	always_comb begin
		case (cfg_ff.src)
			pwc_pkg::PWC_SRC_LOW_POWER: src_tick = low_power_osc_clock;
			pwc_pkg::PWC_SRC_EXT: src_tick = external_ref_clock;
			default: src_tick = internal_ref_clock;
		endcase
	end

	// The selected tick is retimed once so counting logic sees a clean registered enable.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || clr) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= src_tick;
		end
	end

	assign step_en = tick_ff && !debug_halt;

	pwc_prescaler u_prescaler (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clear(clr),
		.tick(step_en),
		.sel(cfg_ff.sel),
		.src0(cfg_ff.src[0]),
		.period(period)
	);

	pwc_modcount u_modcount (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clear(clr),
		.step(period),
		.match(match_ff),
		.count(current_count),
		.wrap(wrap)
	);

	// A wrap in the same cycle as a clearing write keeps the flag set.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			period_flag_ff <= 1'b0;
		end else if (wrap) begin
			period_flag_ff <= 1'b1;
		end else if (wr_sc && pwdata[pwc_pkg::PWC_FLAG_BIT]) begin
			period_flag_ff <= 1'b0;
		end
	end

	assign period_irq = period_flag_ff && cfg_ff.irq_en;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			pwc_pkg::PWC_OFF_SC: begin
				rd_mux[7:0] = {period_flag_ff, cfg_ff};
			end
			pwc_pkg::PWC_OFF_CNT: begin
				rd_mux[7:0] = current_count;
			end
			pwc_pkg::PWC_OFF_MOD: begin
				rd_mux[7:0] = match_ff;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Read data is captured in the setup cycle and held through the access phase.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_ff <= rd_mux;
		end
	end

	reset_state_a: assert property (
		@(posedge sys_clk)
		sys_rst |=> (current_count == 8'h00) && (match_ff == 8'h00) &&
			(cfg_ff.sel == 4'h0) && (cfg_ff.src == 2'h0) && !period_flag_ff
	) else $error("Reset state not reached.");

	count_readonly_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_cnt && !clr && !period |=> $stable(current_count)
	) else $error("Write to count register changed the count.");

	match_write_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_mod |=> (current_count == 8'h00) && (match_ff == $past(pwdata[7:0]))
	) else $error("Match write did not clear the count.");

	cfg_clear_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		cfg_change |=> (current_count == 8'h00) && !tick_ff
	) else $error("Changed source or divider did not clear the count.");

	same_cfg_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_sc && !cfg_change && !period |=> $stable(current_count)
	) else $error("Unchanged divider write disturbed the count.");

	off_hold_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(cfg_ff.sel == 4'h0) |-> !period ##1 ((cfg_ff.sel != 4'h0) || !period)
	) else $error("Prescaler produced a period while off.");

	step_count_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		period && !clr && (current_count != match_ff) |=>
			current_count == $past(current_count) + 8'h01
	) else $error("Counter did not advance by one.");

	wrap_flag_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wrap && !clr |=> (current_count == 8'h00) && period_flag_ff
	) else $error("Wrap did not clear the count and set the flag.");

	zero_match_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(match_ff == 8'h00) && period |=> period_flag_ff
	) else $error("Zero match did not flag on a period.");

	irq_follow_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wrap |=> (period_irq == cfg_ff.irq_en)
	) else $error("Interrupt request does not follow flag and enable.");

	flag_clear_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_sc && pwdata[7] && !wrap |=> !period_flag_ff && !period_irq
	) else $error("Writing one did not clear the flag.");

	halt_freeze_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		debug_halt && !clr |=> $stable(current_count)
	) else $error("Count moved during debug halt.");

	rd_count_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		psel && !penable && !pwrite && (paddr == pwc_pkg::PWC_OFF_CNT) |=>
			prdata == {24'h00_0000, $past(current_count)}
	) else $error("Count read returned a wrong value.");

	rd_match_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		psel && !penable && !pwrite && (paddr == pwc_pkg::PWC_OFF_MOD) |=>
			prdata == {24'h00_0000, $past(match_ff)}
	) else $error("Match read returned a wrong value.");

	rd_status_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		psel && !penable && !pwrite && (paddr == pwc_pkg::PWC_OFF_SC) |=>
			prdata[7:0] == {$past(period_flag_ff), $past(cfg_ff.src), $past(cfg_ff.irq_en),
			$past(cfg_ff.sel)}
	) else $error("Status read returned a wrong layout.");

	rd_upper_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		psel && !penable && !pwrite |=> prdata[31:8] == 24'h00_0000
	) else $error("Upper read bits are not zero.");

	rd_unmapped_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		psel && !penable && !pwrite && !addr_ok |=> prdata == 32'h0000_0000
	) else $error("Unmapped read returned data.");

	rd_stable_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!(psel && !penable && !pwrite) |=> $stable(prdata)
	) else $error("Read data changed outside a read setup.");

	cnt_write_err_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_cnt |-> !pslverr
	) else $error("Count write raised an error response.");

	src_write_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_sc |=> cfg_ff.src == $past(pwdata[pwc_pkg::PWC_SRC_HI:pwc_pkg::PWC_SRC_LO])
	) else $error("Source field did not take the written value.");

	sel_write_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_sc |=> cfg_ff.sel == $past(pwdata[pwc_pkg::PWC_SEL_HI:pwc_pkg::PWC_SEL_LO])
	) else $error("Divider field did not take the written value.");

	ie_write_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		wr_sc |=> cfg_ff.irq_en == $past(pwdata[pwc_pkg::PWC_IE_BIT])
	) else $error("Interrupt enable did not take the written value.");

	cfg_hold_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!wr_sc |=> $stable(cfg_ff)
	) else $error("Configuration changed without a status write.");

	match_hold_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!wr_mod |=> $stable(match_ff)
	) else $error("Match value changed without a match write.");

	flag_hold_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		period_flag_ff && !(wr_sc && pwdata[pwc_pkg::PWC_FLAG_BIT]) |=> period_flag_ff
	) else $error("Flag dropped without a write of one.");

	flag_rise_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!period_flag_ff && !wrap |=> !period_flag_ff
	) else $error("Flag set without a wrap.");

	prescale_clear_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		clr |=> u_prescaler.div_cnt_ff == pwc_pkg::PWC_DIV_RST
	) else $error("Clearing write left the prescaler running.");

	off_count_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(cfg_ff.sel == pwc_pkg::PWC_SEL_OFF) && !clr |=> $stable(current_count)
	) else $error("Count moved while the prescaler was off.");

	halt_prescale_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		debug_halt && !clr |=> $stable(u_prescaler.div_cnt_ff)
	) else $error("Prescaler moved during debug halt.");

	tick_retime_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!clr |=> tick_ff == $past(src_tick)
	) else $error("Selected source tick was not retimed.");

	idle_count_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!period && !clr |=> $stable(current_count)
	) else $error("Count moved without a prescaler period.");

	irq_idle_a: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		!period_flag_ff |-> !period_irq
	) else $error("Interrupt request without the flag.");

endmodule : pwc_top

// file: periodic_wakeup_counter_bench.sv
// Self-checking bench for the periodic wake-up counter.
// Assumes pwc_top and pwc_pkg are compiled first; the bench drives all ports.
`timescale 1ns/100ps
module periodic_wakeup_counter_bench;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] src_tick = 3'h0;
	logic debug_halt = 1'b0;
	logic period_irq;
	logic [31:0] rd;
	logic err;
	int n_errors = 0;
	int checks = 0;
	int s;
	localparam logic [31:0] SC = pwc_pkg::PWC_OFF_SC;
	localparam logic [31:0] CNT = pwc_pkg::PWC_OFF_CNT;
	localparam logic [31:0] MD = pwc_pkg::PWC_OFF_MOD;

	pwc_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .low_power_osc_clock(src_tick[0]), .external_ref_clock(src_tick[1]),
		.internal_ref_clock(src_tick[2]), .debug_halt(debug_halt), .period_irq(period_irq));

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	task complete_run;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready under a bound, then releases.
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task rd_chk(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rd_chk

	// Sends n one-cycle pulses on the chosen source input.
	task tick(input int which, input int n);
		repeat (n) begin
			src_tick[which] <= 1'b1;
			@(posedge sys_clk);
			src_tick[which] <= 1'b0;
			@(posedge sys_clk);
		end
	endtask : tick

	initial begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd_chk(SC, 32'h00);
		rd_chk(CNT, 32'h00);
		rd_chk(MD, 32'h00);
		apb(1'b1, CNT, 32'h55);
		rd_chk(CNT, 32'h00);
		apb(1'b0, 32'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, MD, 32'h02);
		apb(1'b1, SC, 32'h18);
		tick(0, 1);
		rd_chk(CNT, 32'h01);
		tick(0, 1);
		rd_chk(SC, 32'h18);
		tick(0, 1);
		rd_chk(CNT, 32'h00);
		rd_chk(SC, 32'h98);
		chk({31'h0, period_irq}, 32'h1);
		apb(1'b1, SC, 32'h98);
		rd_chk(SC, 32'h18);
		chk({31'h0, period_irq}, 32'h0);
		tick(0, 1);
		debug_halt <= 1'b1;
		tick(0, 3);
		rd_chk(CNT, 32'h01);
		debug_halt <= 1'b0;
		tick(0, 1);
		rd_chk(CNT, 32'h02);
		apb(1'b1, MD, 32'hFF);
		rd_chk(CNT, 32'h00);
		tick(0, 3);
		rd_chk(MD, 32'hFF);
		apb(1'b1, SC, 32'h18);
		rd_chk(CNT, 32'h03);
		apb(1'b1, SC, 32'h38);
		rd_chk(CNT, 32'h00);
		tick(0, 2);
		rd_chk(CNT, 32'h00);
		tick(1, 1000);
		rd_chk(CNT, 32'h01);
		for (s = 0; s < 4; s++) begin
			apb(1'b1, SC, {25'h0, s[1:0], 5'h00});
			tick(s > 1 ? 2 : s, 3);
			rd_chk(CNT, 32'h00);
		end
		apb(1'b1, MD, 32'h00);
		apb(1'b1, SC, 32'h4B);
		tick(2, 9);
		rd_chk(SC, 32'h4B);
		tick(2, 1);
		rd_chk(SC, 32'hCB);
		apb(1'b1, SC, 32'hCB);
		tick(2, 10);
		rd_chk(SC, 32'hCB);
		apb(1'b1, MD, 32'h10);
		apb(1'b1, SC, 32'h81);
		tick(0, 7);
		rd_chk(CNT, 32'h00);
		tick(0, 1);
		rd_chk(CNT, 32'h01);
		apb(1'b1, SC, 32'h21);
		rd_chk(CNT, 32'h00);
		tick(1, 8);
		rd_chk(CNT, 32'h00);
		complete_run();
	end
endmodule : periodic_wakeup_counter_bench
